// [src/int_sel_consts.svh]
// Constants of the interrupt selector: addresses, field layout, reset values, codes
// Assumes inclusion by bare name from the package and the design modules
`ifndef INT_SEL_CONSTS_SVH
`define INT_SEL_CONSTS_SVH

// Register byte addresses
`define ADDR_SEL_HIGH 32'h019c0000
`define ADDR_SEL_LOW 32'h019c0004
`define ADDR_LINE_STATUS 32'h019c0008

// Line counts and selector width
`define NUM_LINES 16
`define NUM_FIXED 4
`define NUM_MASKABLE 12
`define FIELDS_PER_REG 6
`define SEL_W 5

// Field positions inside one selector register
`define FIELD_LSB_0 0
`define FIELD_LSB_1 5
`define FIELD_LSB_2 10
`define FIELD_LSB_3 16
`define FIELD_LSB_4 21
`define FIELD_LSB_5 26
`define FIELD_MASK 32'h7fff7fff

// Reset values of the selector registers
`define RESET_SEL_LOW 32'h250718a4
`define RESET_SEL_HIGH 32'h08202d43

// Status register layout
`define STATUS_RSVD_BIT 16

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Selector codes of the event sources
`define CODE_HOST 5'h00
`define CODE_TIMER0 5'h01
`define CODE_TIMER1 5'h02
`define CODE_MEMIF_A 5'h03
`define CODE_PIN4 5'h04
`define CODE_PIN5 5'h05
`define CODE_PIN6 5'h06
`define CODE_PIN7 5'h07
`define CODE_DMA_DONE 5'h08
`define CODE_DEBUG_DMA 5'h09
`define CODE_DEBUG_RX 5'h0a
`define CODE_DEBUG_TX 5'h0b
`define CODE_SER0_TX 5'h0c
`define CODE_SER0_RX 5'h0d
`define CODE_SER1_TX 5'h0e
`define CODE_SER1_RX 5'h0f
`define CODE_PIN0 5'h10
`define CODE_SER2_TX 5'h11
`define CODE_SER2_RX 5'h12
`define CODE_TIMER2 5'h13
`define CODE_MEMIF_B 5'h14
`define CODE_RSVD_A 5'h15
`define CODE_RSVD_B 5'h16
`define CODE_CELL_BUS 5'h17
`define CODE_RSVD_LO 5'h18
`define CODE_RSVD_HI 5'h1d
`define CODE_VITERBI 5'h1e
`define CODE_TURBO 5'h1f

`endif

// [src/int_sel_pkg.sv]
// Types shared by the interrupt selector modules
// Assumes the constants header sits beside this file
`include "int_sel_consts.svh"

package int_sel_pkg;

  typedef enum logic [1:0] {
    REG_HIGH = 2'h0,
    REG_LOW = 2'h1,
    REG_STATUS = 2'h2,
    REG_NONE = 2'h3
  } reg_id_t;

  typedef enum logic [0:0] {
    WR_IDLE = 1'h0,
    WR_RESP = 1'h1
  } wr_state_t;

  typedef logic [`SEL_W-1:0] sel_code_t;

endpackage : int_sel_pkg

// [src/sel_reg.sv]
// One selector control register with byte strobes and fixed unused bits
// Assumes write enable comes from the bus slave on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "int_sel_consts.svh"

module sel_reg #(
  parameter logic [31:0] RESET_VAL = 32'h00000000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write port
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Stored value
  output logic [31:0] value_r
);

  logic [31:0] merged;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      merged[b*8 +: 8] = wstrb[b] ? wdata[b*8 +: 8] : value_r[b*8 +: 8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_r <= RESET_VAL;
    end else if (wr_en) begin
      value_r <= merged & `FIELD_MASK;
    end
  end

endmodule : sel_reg

`default_nettype wire

// [src/line_mux.sv]
// Picks one event level out of the source vector for one maskable line
// Assumes all sources are levels on the same clock
`timescale 1ns/100ps
`default_nettype none

module line_mux #(
  parameter int SEL_W = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sources and selector
  input wire logic [(1<<SEL_W)-1:0] src,
  input wire logic [SEL_W-1:0] sel,
  // Selected line
  output logic line_r
);

  // Registered so the line follows its source one clock later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_r <= 1'b0;
    end else begin
      line_r <= src[sel];
    end
  end

endmodule : line_mux

`default_nettype wire

// [src/cpu_interrupt_selector.sv]
// Interrupt selector: routes peripheral event levels onto twelve of the core's sixteen interrupt lines
// Assumes an AXI4-Lite master and event sources all on aclk; events are levels
`timescale 1ns/100ps
`default_nettype none
`include "int_sel_consts.svh"

module cpu_interrupt_selector (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Fixed sources
  input wire logic reset_req,
  input wire logic nmi_req,
  // Selectable event sources
  input wire logic host_irq,
  input wire logic timer0_irq,
  input wire logic timer1_irq,
  input wire logic timer2_irq,
  input wire logic memif_a_refresh_irq,
  input wire logic memif_b_refresh_irq,
  input wire logic pin_event_0,
  input wire logic pin_event_4,
  input wire logic pin_event_5,
  input wire logic pin_event_6,
  input wire logic pin_event_7,
  input wire logic dma_done_irq,
  input wire logic debug_dma_event,
  input wire logic debug_exchange_rx,
  input wire logic debug_exchange_tx,
  input wire logic serial0_tx_irq,
  input wire logic serial0_rx_irq,
  input wire logic serial1_tx_irq,
  input wire logic serial1_rx_irq,
  input wire logic serial2_tx_irq,
  input wire logic serial2_rx_irq,
  input wire logic cell_bus_irq,
  input wire logic viterbi_cop_irq,
  input wire logic turbo_cop_irq,
  // Core interrupt lines, bit 0 highest priority
  output logic [`NUM_LINES-1:0] core_int
);

  localparam int SRC_N = 1 << `SEL_W;

  // Address decode, shared by the write and read paths
  function automatic int_sel_pkg::reg_id_t decode_addr(input logic [31:0] addr);
    logic [31:0] word;
    word = {addr[31:2], 2'h0};
    if (word == `ADDR_SEL_HIGH) begin
      decode_addr = int_sel_pkg::REG_HIGH;
    end else if (word == `ADDR_SEL_LOW) begin
      decode_addr = int_sel_pkg::REG_LOW;
    end else if (word == `ADDR_LINE_STATUS) begin
      decode_addr = int_sel_pkg::REG_STATUS;
    end else begin
      decode_addr = int_sel_pkg::REG_NONE;
    end
  endfunction : decode_addr

  // Codes that name no source
  function automatic logic is_reserved(input int_sel_pkg::sel_code_t code);
    is_reserved = (code == `CODE_RSVD_A) || (code == `CODE_RSVD_B) ||
                  ((code >= `CODE_RSVD_LO) && (code <= `CODE_RSVD_HI));
  endfunction : is_reserved

  // Bit position of a field within its register
  function automatic int field_lsb(input int idx);
    case (idx)
      0: field_lsb = `FIELD_LSB_0;
      1: field_lsb = `FIELD_LSB_1;
      2: field_lsb = `FIELD_LSB_2;
      3: field_lsb = `FIELD_LSB_3;
      4: field_lsb = `FIELD_LSB_4;
      default: field_lsb = `FIELD_LSB_5;
    endcase
  endfunction : field_lsb

  // Bus state
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  int_sel_pkg::wr_state_t wr_state_r;

  // Datapath state
  logic [31:0] sel_high;
  logic [31:0] sel_low;
  logic [`NUM_FIXED-1:0] fixed_r;
  logic [`NUM_MASKABLE-1:0] mask_lines;
  logic [SRC_N-1:0] src_vec;
  logic [`NUM_MASKABLE-1:0] field_rsvd;
  logic rsvd_any;

  // Handshake terms
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic b_done;
  logic aw_held_nxt;
  logic w_held_nxt;
  logic ar_take;
  logic rvalid_nxt;
  int_sel_pkg::reg_id_t wr_id;
  int_sel_pkg::reg_id_t rd_id;
  logic wr_high;
  logic wr_low;
  logic [31:0] rd_value;

  assign aw_take = awvalid & awready_r;
  assign w_take = wvalid & wready_r;
  assign wr_fire = aw_held_r & w_held_r & (wr_state_r == int_sel_pkg::WR_IDLE);
  assign b_done = bvalid_r & bready;
  assign aw_held_nxt = (aw_held_r | aw_take) & ~b_done;
  assign w_held_nxt = (w_held_r | w_take) & ~b_done;
  assign ar_take = arvalid & arready_r;
  assign rvalid_nxt = ar_take | (rvalid_r & ~rready);
  assign wr_id = decode_addr(awaddr_r);
  assign rd_id = decode_addr(araddr);
  assign wr_high = wr_fire & (wr_id == int_sel_pkg::REG_HIGH);
  assign wr_low = wr_fire & (wr_id == int_sel_pkg::REG_LOW);

  // Write address and data are taken in either order and held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      awready_r <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      awready_r <= ~aw_held_nxt;
      if (aw_take) begin
        awaddr_r <= awaddr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      wready_r <= 1'b0;
    end else begin
      w_held_r <= w_held_nxt;
      wready_r <= ~w_held_nxt;
      if (w_take) begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
    end
  end

  // Write response; the status register ignores writes, unmapped words answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= int_sel_pkg::WR_IDLE;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      case (wr_state_r)
        int_sel_pkg::WR_IDLE: begin
          if (wr_fire) begin
            wr_state_r <= int_sel_pkg::WR_RESP;
            bvalid_r <= 1'b1;
            bresp_r <= (wr_id == int_sel_pkg::REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
          end
        end
        int_sel_pkg::WR_RESP: begin
          if (bready) begin
            wr_state_r <= int_sel_pkg::WR_IDLE;
            bvalid_r <= 1'b0;
          end
        end
        default: begin
          wr_state_r <= int_sel_pkg::WR_IDLE;
          bvalid_r <= 1'b0;
        end
      endcase
    end
  end

  // Selector registers; defaults give the documented power-up routing
  sel_reg #(
    .RESET_VAL(`RESET_SEL_HIGH)
  ) u_sel_high (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_high),
    .wdata(wdata_r),
    .wstrb(wstrb_r),
    .value_r(sel_high)
  );

  sel_reg #(
    .RESET_VAL(`RESET_SEL_LOW)
  ) u_sel_low (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_low),
    .wdata(wdata_r),
    .wstrb(wstrb_r),
    .value_r(sel_low)
  );

  // Event source vector indexed by selector code; reserved codes stay low
  always_comb begin
    src_vec = '0;
    src_vec[`CODE_HOST] = host_irq;
    src_vec[`CODE_TIMER0] = timer0_irq;
    src_vec[`CODE_TIMER1] = timer1_irq;
    src_vec[`CODE_MEMIF_A] = memif_a_refresh_irq;
    src_vec[`CODE_PIN4] = pin_event_4;
    src_vec[`CODE_PIN5] = pin_event_5;
    src_vec[`CODE_PIN6] = pin_event_6;
    src_vec[`CODE_PIN7] = pin_event_7;
    src_vec[`CODE_DMA_DONE] = dma_done_irq;
    src_vec[`CODE_DEBUG_DMA] = debug_dma_event;
    src_vec[`CODE_DEBUG_RX] = debug_exchange_rx;
    src_vec[`CODE_DEBUG_TX] = debug_exchange_tx;
    src_vec[`CODE_SER0_TX] = serial0_tx_irq;
    src_vec[`CODE_SER0_RX] = serial0_rx_irq;
    src_vec[`CODE_SER1_TX] = serial1_tx_irq;
    src_vec[`CODE_SER1_RX] = serial1_rx_irq;
    src_vec[`CODE_PIN0] = pin_event_0;
    src_vec[`CODE_SER2_TX] = serial2_tx_irq;
    src_vec[`CODE_SER2_RX] = serial2_rx_irq;
    src_vec[`CODE_TIMER2] = timer2_irq;
    src_vec[`CODE_MEMIF_B] = memif_b_refresh_irq;
    src_vec[`CODE_CELL_BUS] = cell_bus_irq;
    src_vec[`CODE_VITERBI] = viterbi_cop_irq;
    src_vec[`CODE_TURBO] = turbo_cop_irq;
  end

  // One multiplexer per maskable line: lines 4-9 from the low register, 10-15 from the high
  generate
    for (genvar g = 0; g < `NUM_MASKABLE; g++) begin : g_line
      localparam int LSB = field_lsb(g % `FIELDS_PER_REG);
      int_sel_pkg::sel_code_t code;
      if (g < `FIELDS_PER_REG) begin : g_low
        assign code = sel_low[LSB +: `SEL_W];
      end else begin : g_high
        assign code = sel_high[LSB +: `SEL_W];
      end
      assign field_rsvd[g] = is_reserved(code);
      line_mux #(
        .SEL_W(`SEL_W)
      ) u_mux (
        .aclk(aclk),
        .aresetn(aresetn),
        .src(src_vec),
        .sel(code),
        .line_r(mask_lines[g])
      );
    end
  endgenerate

  // A reserved code only reports here; its line simply stays low
  assign rsvd_any = |field_rsvd;

  // Fixed lines are wired past the selector, registered to match the maskable ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fixed_r <= '0;
    end else begin
      fixed_r <= {2'b00, nmi_req, reset_req};
    end
  end

  // Bit n is line n, so priority falls with the bit number
  assign core_int = {mask_lines, fixed_r};

  // Read data: selectors read back with unused bits zero, status shows live lines
  always_comb begin
    case (rd_id)
      int_sel_pkg::REG_HIGH: rd_value = sel_high & `FIELD_MASK;
      int_sel_pkg::REG_LOW: rd_value = sel_low & `FIELD_MASK;
      int_sel_pkg::REG_STATUS: begin
        rd_value = 32'h00000000;
        rd_value[`NUM_LINES-1:0] = core_int;
        rd_value[`STATUS_RSVD_BIT] = rsvd_any;
      end
      default: rd_value = 32'h00000000;
    endcase
  end

  // Read channel; one read outstanding at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      arready_r <= ~rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_value;
        rresp_r <= (rd_id == int_sel_pkg::REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

endmodule : cpu_interrupt_selector

`default_nettype wire

// [testbench/int_sel_props.sv]
// Checker of bus handshakes and fixed core lines, bound to the selector top
// Assumes one clock domain with a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "int_sel_consts.svh"

module int_sel_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Core lines
  input wire logic reset_req,
  input wire logic nmi_req,
  input wire logic [`NUM_LINES-1:0] core_int
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_take_s;
    awvalid && awready && wvalid && wready;
  endsequence

  // Status reads may set bit 15, so only selector reads are watched
  logic sel_rd_r;
  always_ff @(posedge aclk) begin
    if (arvalid && arready) begin
      sel_rd_r <= (araddr & 32'hfffffff8) == `ADDR_SEL_HIGH;
    end
  end

  rsvd_lines_a:
    assert property (core_int[3:2] == 2'h0) else $error("reserved line driven");
  reset_route_a:
    assert property ($past(aresetn) |-> core_int[0] == $past(reset_req))
      else $error("line 0 not following reset request");
  nmi_route_a:
    assert property ($past(aresetn) |-> core_int[1] == $past(nmi_req))
      else $error("line 1 not following nmi request");
  wr_answer_a:
    assert property (wr_take_s |=> !awready && !wready ##1 bvalid)
      else $error("write not answered in time");
  b_hold_a:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
  rd_answer_a:
    assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read not answered in time");
  r_hold_a:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped");
  unused_bits_a:
    assert property (rvalid && sel_rd_r |-> !rdata[15] && !rdata[31])
      else $error("unused selector bit reads one");
endmodule : int_sel_checker

bind cpu_interrupt_selector int_sel_checker CHK (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
  .reset_req, .nmi_req, .core_int
);
`default_nettype wire

// [testbench/event_src_model.sv]
// Model of the peripheral event sources feeding the selector
// Assumes requests from the bench on aclk, one bit per selector code
`timescale 1ns/100ps
`default_nettype none

module event_src_model (
  // Clock
  input wire logic aclk,
  // Requested levels
  input wire logic [31:0] req,
  // Event levels
  output logic [31:0] ev
);
  // Sources are flops on the core clock, so levels only move after an edge
  always_ff @(posedge aclk) begin
    ev <= req;
  end
endmodule : event_src_model
`default_nettype wire

// [testbench/cpu_interrupt_selector_tb_top.sv]
// Self-checking bench of the interrupt selector
// Assumes design, checker and source model are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "int_sel_consts.svh"

module cpu_interrupt_selector_tb_top;
  // Codes that name a real source; the rest select nothing
  localparam logic [31:0] VALID_CODES = 32'hc09fffff;
  typedef struct {int line; logic [4:0] code; logic hit;} row_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, reset_req, nmi_req;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata, req, ev, lo_m, hi_m;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] core_int;
  int n_fail, checks_done;
  row_t rows [32];

  cpu_interrupt_selector DUT (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .reset_req, .nmi_req,
    .host_irq(ev[0]), .timer0_irq(ev[1]), .timer1_irq(ev[2]),
    .memif_a_refresh_irq(ev[3]), .pin_event_4(ev[4]), .pin_event_5(ev[5]),
    .pin_event_6(ev[6]), .pin_event_7(ev[7]), .dma_done_irq(ev[8]),
    .debug_dma_event(ev[9]), .debug_exchange_rx(ev[10]), .debug_exchange_tx(ev[11]),
    .serial0_tx_irq(ev[12]), .serial0_rx_irq(ev[13]), .serial1_tx_irq(ev[14]),
    .serial1_rx_irq(ev[15]), .pin_event_0(ev[16]), .serial2_tx_irq(ev[17]),
    .serial2_rx_irq(ev[18]), .timer2_irq(ev[19]), .memif_b_refresh_irq(ev[20]),
    .cell_bus_irq(ev[23]), .viterbi_cop_irq(ev[30]), .turbo_cop_irq(ev[31]),
    .core_int
  );
  event_src_model SRC (.aclk, .req, .ev);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  function automatic logic [31:0] pack(input logic [4:0] a, b, c, d, e, f);
    return {1'b0, f, e, d, 1'b0, c, b, a};
  endfunction : pack

  function automatic int pos(input int n);
    return 5 * ((n - 4) % 6) + ((n - 4) % 6 > 2 ? 1 : 0);
  endfunction : pos

  function automatic logic [15:0] exp_lines(input logic [31:0] v, input logic rq, nq);
    logic [15:0] e;
    logic [31:0] r;
    e = {14'h0, nq, rq};
    for (int n = 4; n < 16; n++) begin
      r = n < 10 ? lo_m : hi_m;
      e[n] = v[r[pos(n) +: 5]] & VALID_CODES[r[pos(n) +: 5]];
    end
    return e;
  endfunction : exp_lines

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
    logic done;
    logic [31:0] m;
    m = 32'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      done = bvalid === 1'b1 && bready;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!done);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    for (int b = 0; b < 4; b++) if (s[b]) m[8*b +: 8] = 8'hff;
    if (er == `RESP_OKAY && a == `ADDR_SEL_LOW) lo_m = (lo_m & ~m) | (d & m & `FIELD_MASK);
    if (er == `RESP_OKAY && a == `ADDR_SEL_HIGH) hi_m = (hi_m & ~m) | (d & m & `FIELD_MASK);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      done = rvalid === 1'b1 && rready;
      d = rdata;
      r = rresp;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!done);
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
  endtask : rchk

  task automatic setf(input int n, input logic [4:0] c);
    logic [31:0] v;
    v = n < 10 ? lo_m : hi_m;
    v[pos(n) +: 5] = c;
    wr(n < 10 ? `ADDR_SEL_LOW : `ADDR_SEL_HIGH, v | 32'h80008000, 4'hf, `RESP_OKAY);
    rchk(n < 10 ? `ADDR_SEL_LOW : `ADDR_SEL_HIGH, n < 10 ? lo_m : hi_m);
  endtask : setf

  // Source model adds one cycle, the selector one more
  task automatic settle(input logic [31:0] v, input logic rq, input logic nq);
    @(posedge aclk);
    req <= v;
    reset_req <= rq;
    nmi_req <= nq;
    repeat (2) @(posedge aclk);
    #1 chk({16'h0, core_int}, {16'h0, exp_lines(v, rq, nq)});
  endtask : settle

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (9) @(posedge aclk);
    #1 chk({16'h0, core_int}, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    lo_m = pack(5'h4, 5'h5, 5'h6, 5'h7, 5'h8, 5'h9);
    hi_m = pack(5'h3, 5'ha, 5'hb, 5'h0, 5'h1, 5'h2);
  endtask : do_reset

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, reset_req, nmi_req} = 8'h0;
    {awaddr, wdata, araddr, req} = 128'h0;
    {awprot, arprot, wstrb} = 10'h0;
    n_fail = 0;
    checks_done = 0;
    for (int i = 0; i < 32; i++) begin
      // Software keeps off reserved codes, so those rows take a real source
      rows[i] = '{4 + i % 12, VALID_CODES[i] ? i[4:0] : i[4:0] ^ 5'h10, 1'b1};
    end
    do_reset();
    rchk(`ADDR_SEL_HIGH, hi_m);
    rchk(`ADDR_SEL_LOW, lo_m);
    for (int c = 0; c < 12; c++) settle(32'h1 << c, 1'b0, 1'b0);
    for (int i = 0; i < 32; i++) begin
      setf(rows[i].line, rows[i].code);
      settle(32'h1 << rows[i].code, i[0], i[1]);
      chk({31'h0, core_int[rows[i].line]}, {31'h0, rows[i].hit});
    end
    // Byte strobes: only the low byte may change
    wr(`ADDR_SEL_LOW, 32'h0, 4'h1, `RESP_OKAY);
    rchk(`ADDR_SEL_LOW, lo_m);
    settle(32'hffffffff, 1'b1, 1'b0);
    rchk(`ADDR_LINE_STATUS, {16'h0, exp_lines(32'hffffffff, 1'b1, 1'b0)});
    // Unmapped and read-only places leave the high selector alone
    wr(`ADDR_SEL_HIGH + 32'h100, 32'hffffffff, 4'hf, `RESP_SLVERR);
    wr(`ADDR_LINE_STATUS, 32'hffffffff, 4'hf, `RESP_OKAY);
    rchk(`ADDR_SEL_HIGH, hi_m);
    rd(`ADDR_SEL_HIGH + 32'h100, d, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    // Reset in mid-run with every event source and the reset request raised, nmi request low
    do_reset();
    rchk(`ADDR_SEL_LOW, lo_m);
    settle(32'hffffffff, 1'b0, 1'b1);
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    give_verdict();
  end
endmodule : cpu_interrupt_selector_tb_top
`default_nettype wire
